//--- logic/aleu_params.svh
// Flag positions and timing counts of the arithmetic and logic unit
`ifndef ALEU_PARAMS_SVH
`define ALEU_PARAMS_SVH

`define ALEU_FLAG_C       0
`define ALEU_FLAG_Z       1
`define ALEU_FLAG_N       2
`define ALEU_FLAG_V       3
`define ALEU_FLAG_S       4
`define ALEU_FLAG_H       5
`define ALEU_FLAG_W       6
`define ALEU_FLAGS_RESET  6'h00
`define ALEU_BYTE_CYCLES  2'h1
`define ALEU_WORD_CYCLES  2'h2

`endif

//--- logic/aleu_pkg.sv
// Types shared by the arithmetic and logic unit
`default_nettype none
package aleu_pkg;

    typedef enum logic [3:0] {
        ALEU_ADD,
        ALEU_ADD_CARRY,
        ALEU_SUB,
        ALEU_SUB_WITH_CARRY,
        ALEU_SUB_CONSTANT,
        ALEU_SUB_CONST_WITH_CARRY,
        ALEU_WORD_ADD_IMMEDIATE,
        ALEU_WORD_SUB_IMMEDIATE,
        ALEU_AND,
        ALEU_AND_CONSTANT
    } aleu_op_e;

    typedef struct packed {
        aleu_op_e    op;
        logic [7:0]  dst_lo;
        logic [7:0]  dst_hi;
        logic [7:0]  src_reg;
        logic [7:0]  konst;
    } aleu_req_s;

    typedef struct packed {
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic        wr_hi;
        logic [5:0]  flags;
    } aleu_res_s;

endpackage : aleu_pkg
`default_nettype wire

//--- logic/aleu_byte_core.sv
// Combinational 8-bit adder/subtractor with status flag outputs
`default_nettype none
module aleu_byte_core (
    // Operands
    input  wire logic [7:0] a_in,
    input  wire logic [7:0] b_in,
    input  wire logic       cin_in,
    input  wire logic       sub_in,
    // Result
    output logic      [7:0] sum_out,
    output logic            c_out,
    output logic            h_out,
    output logic            v_out
);
    logic [7:0] b_eff;
    logic [8:0] full;
    logic [4:0] half;

    // Subtraction as a + ~b + ~borrow, carry reported as borrow
    always_comb begin
        b_eff   = sub_in ? ~b_in : b_in;
        full    = {1'b0, a_in} + {1'b0, b_eff} + {8'h00, cin_in ^ sub_in};
        half    = {1'b0, a_in[3:0]} + {1'b0, b_eff[3:0]}
                  + {4'h0, cin_in ^ sub_in};
        sum_out = full[7:0];
        c_out   = full[8] ^ sub_in;
        h_out   = half[4] ^ sub_in;
        v_out   = (a_in[7] == b_eff[7]) && (full[7] != a_in[7]);
    end
endmodule : aleu_byte_core
`default_nettype wire

//--- logic/aleu_exec_unit.sv
// Arithmetic and logic execution unit of the 8-bit core
`include "aleu_params.svh"
`default_nettype none
// Function
// - Add registers, optional carry, flags, one clock
// - Subtract registers, optional carry, flags, one clock
// - Subtract constant from register, one clock
// - Subtract constant and carry, one clock
// - Word add immediate on pair, two clocks
// - Word subtract immediate on pair, two clocks
// - AND with register or constant, Z N V
module aleu_exec_unit (
    // Clock and reset
    input  wire logic                 clk_sys_in,
    input  wire logic                 rstn_in,
    // Request from decoder
    input  wire logic                 req_valid_in,
    input  wire aleu_pkg::aleu_req_s  req_in,
    output logic                      req_ready_out,
    // Result to register file
    output logic                      res_valid_out,
    output aleu_pkg::aleu_res_s       res_out,
    // Status flags
    output logic [5:0]                flags_out
);
    typedef enum logic [0:0] {ST_IDLE, ST_WORD_HI} aleu_state_e;

    aleu_state_e          state_reg;
    aleu_pkg::aleu_req_s  hold_reg;
    logic                 wcarry_reg;
    logic                 wzero_reg;
    logic [5:0]           flags_reg;
    logic [5:0]           flags_next;
    aleu_pkg::aleu_res_s  res_reg;
    aleu_pkg::aleu_res_s  res_next;
    logic                 res_valid_reg;

    logic [7:0] a_sel;
    logic [7:0] b_sel;
    logic       cin_sel;
    logic       sub_sel;
    logic [7:0] sum;
    logic       c_o;
    logic       h_o;
    logic       v_o;

    function automatic logic is_word(input aleu_pkg::aleu_op_e op);
        return op == aleu_pkg::ALEU_WORD_ADD_IMMEDIATE
            || op == aleu_pkg::ALEU_WORD_SUB_IMMEDIATE;
    endfunction : is_word

    function automatic logic is_sub(input aleu_pkg::aleu_op_e op);
        return op == aleu_pkg::ALEU_SUB
            || op == aleu_pkg::ALEU_SUB_WITH_CARRY
            || op == aleu_pkg::ALEU_SUB_CONSTANT
            || op == aleu_pkg::ALEU_SUB_CONST_WITH_CARRY
            || op == aleu_pkg::ALEU_WORD_SUB_IMMEDIATE;
    endfunction : is_sub

    assign req_ready_out = (state_reg == ST_IDLE);
    assign res_valid_out = res_valid_reg;
    assign res_out       = res_reg;
    assign flags_out     = flags_reg;

    // ------------------------------------------------------------
    // Operand selection
    // ------------------------------------------------------------
    always_comb begin
        a_sel   = req_in.dst_lo;
        b_sel   = req_in.src_reg;
        cin_sel = 1'b0;
        sub_sel = is_sub(req_in.op);
        if (state_reg == ST_WORD_HI) begin
            // Upper byte of the pair: propagate low-byte carry
            a_sel   = hold_reg.dst_hi;
            b_sel   = 8'h00;
            cin_sel = wcarry_reg;
            sub_sel = is_sub(hold_reg.op);
        end else begin
            unique case (req_in.op)
                aleu_pkg::ALEU_ADD_CARRY,
                aleu_pkg::ALEU_SUB_WITH_CARRY: begin
                    cin_sel = flags_reg[`ALEU_FLAG_C];
                end
                aleu_pkg::ALEU_SUB_CONSTANT,
                aleu_pkg::ALEU_WORD_ADD_IMMEDIATE,
                aleu_pkg::ALEU_WORD_SUB_IMMEDIATE: begin
                    b_sel = req_in.konst;
                end
                aleu_pkg::ALEU_SUB_CONST_WITH_CARRY: begin
                    b_sel   = req_in.konst;
                    cin_sel = flags_reg[`ALEU_FLAG_C];
                end
                default: begin
                end
            endcase
        end
    end

    aleu_byte_core u_core (
        .a_in    (a_sel),
        .b_in    (b_sel),
        .cin_in  (cin_sel),
        .sub_in  (sub_sel),
        .sum_out (sum),
        .c_out   (c_o),
        .h_out   (h_o),
        .v_out   (v_o)
    );

    // ------------------------------------------------------------
    // Result and flag computation
    // ------------------------------------------------------------
    always_comb begin
        flags_next = flags_reg;
        res_next   = res_reg;
        if (state_reg == ST_WORD_HI) begin
            res_next.hi    = sum;
            res_next.wr_hi = 1'b1;
            flags_next[`ALEU_FLAG_C] = c_o;
            flags_next[`ALEU_FLAG_Z] = wzero_reg && (sum == 8'h00);
            flags_next[`ALEU_FLAG_N] = sum[7];
            flags_next[`ALEU_FLAG_V] = v_o;
            flags_next[`ALEU_FLAG_S] = sum[7] ^ v_o;
        end else if (req_valid_in) begin
            res_next.lo    = sum;
            res_next.hi    = req_in.dst_hi;
            res_next.wr_hi = 1'b0;
            if (req_in.op == aleu_pkg::ALEU_AND
                || req_in.op == aleu_pkg::ALEU_AND_CONSTANT) begin
                res_next.lo = req_in.dst_lo
                    & (req_in.op == aleu_pkg::ALEU_AND ? req_in.src_reg
                                                       : req_in.konst);
                flags_next[`ALEU_FLAG_Z] = (res_next.lo == 8'h00);
                flags_next[`ALEU_FLAG_N] = res_next.lo[7];
                flags_next[`ALEU_FLAG_V] = 1'b0;
            end else if (!is_word(req_in.op)) begin
                flags_next[`ALEU_FLAG_C] = c_o;
                flags_next[`ALEU_FLAG_Z] = (sum == 8'h00);
                flags_next[`ALEU_FLAG_N] = sum[7];
                flags_next[`ALEU_FLAG_V] = v_o;
                flags_next[`ALEU_FLAG_H] = h_o;
            end
        end
        res_next.flags = flags_next;
    end

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (req_valid_in && is_word(req_in.op)) begin
                        state_reg <= ST_WORD_HI;
                    end
                end
                ST_WORD_HI: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hold_reg   <= '0;
            wcarry_reg <= 1'b0;
            wzero_reg  <= 1'b0;
        end else if (state_reg == ST_IDLE && req_valid_in) begin
            hold_reg   <= req_in;
            // Carry into high byte: add carry, or borrow inverted later
            wcarry_reg <= c_o;
            wzero_reg  <= (sum == 8'h00);
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flags_reg     <= `ALEU_FLAGS_RESET;
            res_reg       <= '0;
            res_valid_reg <= 1'b0;
        end else begin
            flags_reg     <= flags_next;
            res_reg       <= res_next;
            res_valid_reg <= (state_reg == ST_WORD_HI)
                || (req_valid_in && !is_word(req_in.op));
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_byte_one_clock: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        (req_ready_out && req_valid_in && !is_word(req_in.op))
        |=> res_valid_out && req_ready_out)
        else $error("byte op did not finish in one clock");

    a_word_two_clocks: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        (req_ready_out && req_valid_in && is_word(req_in.op))
        |=> !res_valid_out && !req_ready_out
        ##1 res_valid_out && res_out.wr_hi)
        else $error("word op did not finish in two clocks");

    a_add_result: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        (req_ready_out && req_valid_in && req_in.op == aleu_pkg::ALEU_ADD)
        |=> res_out.lo == 8'($past(req_in.dst_lo) + $past(req_in.src_reg)))
        else $error("add result wrong");

    a_sub_result: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        (req_ready_out && req_valid_in
         && req_in.op == aleu_pkg::ALEU_SUB_CONSTANT)
        |=> res_out.lo == 8'($past(req_in.dst_lo) - $past(req_in.konst))
            && flags_out[`ALEU_FLAG_C]
               == ($past(req_in.konst) > $past(req_in.dst_lo)))
        else $error("subtract constant result or borrow wrong");

    a_and_flags: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        (req_ready_out && req_valid_in
         && req_in.op == aleu_pkg::ALEU_AND_CONSTANT)
        |=> !flags_out[`ALEU_FLAG_V]
            && $stable(flags_out[`ALEU_FLAG_C])
            && $stable(flags_out[`ALEU_FLAG_H]))
        else $error("logic op flags wrong");

    a_word_keep_h: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        (req_ready_out && req_valid_in && is_word(req_in.op))
        |=> $stable(flags_out[`ALEU_FLAG_H])
        ##1 $stable(flags_out[`ALEU_FLAG_H]))
        else $error("word op disturbed half carry");

    a_word_sub_value: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        (req_ready_out && req_valid_in
         && req_in.op == aleu_pkg::ALEU_WORD_SUB_IMMEDIATE)
        |=> ##1 {res_out.hi, res_out.lo}
            == 16'({$past(req_in.dst_hi, 2), $past(req_in.dst_lo, 2)}
                   - {8'h00, $past(req_in.konst, 2)}))
        else $error("word subtract result wrong");

    a_sbc_carry_in: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        (req_ready_out && req_valid_in
         && req_in.op == aleu_pkg::ALEU_SUB_WITH_CARRY)
        |=> res_out.lo == 8'($past(req_in.dst_lo) - $past(req_in.src_reg)
            - {7'h00, $past(flags_out[`ALEU_FLAG_C])}))
        else $error("subtract with carry result wrong");

    a_sub_const_with_carry_op_value: assert property (@(posedge clk_sys_in)
        disable iff (!rstn_in)
        (req_ready_out && req_valid_in
         && req_in.op == aleu_pkg::ALEU_SUB_CONST_WITH_CARRY)
        |=> res_out.lo == 8'($past(req_in.dst_lo) - $past(req_in.konst)
            - {7'h00, $past(flags_out[`ALEU_FLAG_C])}))
        else $error("subtract constant with carry wrong");

endmodule : aleu_exec_unit
`default_nettype wire

//--- tb/aleu_rf_model.sv
// Register pair model that takes the unit's results
`default_nettype none
module aleu_rf_model (
    // Clock and reset
    input  wire logic                clk_sys_in,
    input  wire logic                rstn_in,
    // Result from the unit
    input  wire logic                res_valid_in,
    input  wire aleu_pkg::aleu_res_s res_in,
    // Stored pair
    output logic [15:0]              pair_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // High byte is written only for pair results
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pair_out <= 16'h0000;
        end else if (res_valid_in) begin
            pair_out[7:0] <= res_in.lo;
            if (res_in.wr_hi) begin
                pair_out[15:8] <= res_in.hi;
            end
        end
    end
endmodule : aleu_rf_model
`default_nettype wire

//--- tb/arith_logic_exec_unit_tb_top.sv
// Self-checking bench of the arithmetic and logic unit
`include "aleu_params.svh"
`default_nettype none
module arith_logic_exec_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                clk;
    logic                rstn;
    logic                req_v;
    aleu_pkg::aleu_req_s req;
    logic                rdy;
    logic                rv;
    aleu_pkg::aleu_res_s res;
    logic [5:0]          flg;
    logic [15:0]         pair;
    logic [5:0]          e_flg;
    logic [15:0]         e_pair;
    int                  fail_count = 0;
    int                  cmp_count = 0;
    int                  cycles = 0;

    aleu_exec_unit uut (
        .clk_sys_in    (clk),
        .rstn_in       (rstn),
        .req_valid_in  (req_v),
        .req_in        (req),
        .req_ready_out (rdy),
        .res_valid_out (rv),
        .res_out       (res),
        .flags_out     (flg)
    );
    aleu_rf_model rf (
        .clk_sys_in   (clk),
        .rstn_in      (rstn),
        .res_valid_in (rv),
        .res_in       (res),
        .pair_out     (pair)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t data %h exp %h", $time, got, exp);
        end
    endtask : cmp_data

    task automatic cmp_flags(input logic [5:0] got, input logic [5:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t flags %h exp %h", $time, got, exp);
        end
    endtask : cmp_flags

    // Reference arithmetic; unlisted flags stay as they were
    task automatic expect_op(input aleu_pkg::aleu_op_e op,
                             input logic [15:0] w, input logic [7:0] b);
        logic        sub;
        logic        cin;
        logic [8:0]  r;
        logic [4:0]  h;
        logic [16:0] x;
        sub = op inside {aleu_pkg::ALEU_SUB, aleu_pkg::ALEU_SUB_WITH_CARRY,
            aleu_pkg::ALEU_SUB_CONSTANT, aleu_pkg::ALEU_SUB_CONST_WITH_CARRY};
        cin = e_flg[`ALEU_FLAG_C] & (op inside {aleu_pkg::ALEU_ADD_CARRY,
            aleu_pkg::ALEU_SUB_WITH_CARRY, aleu_pkg::ALEU_SUB_CONST_WITH_CARRY});
        if (op inside {aleu_pkg::ALEU_WORD_ADD_IMMEDIATE,
                       aleu_pkg::ALEU_WORD_SUB_IMMEDIATE}) begin
            sub = op == aleu_pkg::ALEU_WORD_SUB_IMMEDIATE;
            x = sub ? {1'b0, w} - {9'h000, b} : {1'b0, w} + {9'h000, b};
            e_pair = x[15:0];
            e_flg[`ALEU_FLAG_C] = x[16];
            e_flg[`ALEU_FLAG_Z] = x[15:0] == 16'h0000;
            e_flg[`ALEU_FLAG_N] = x[15];
            e_flg[`ALEU_FLAG_V] = (w[15] ^ x[15]) & ~(w[15] ^ sub);
            e_flg[`ALEU_FLAG_S] = x[15] ^ e_flg[`ALEU_FLAG_V];
        end else begin
            if (op inside {aleu_pkg::ALEU_AND,
                           aleu_pkg::ALEU_AND_CONSTANT}) begin
                r = {1'b0, w[7:0] & b};
                e_flg[`ALEU_FLAG_V] = 1'b0;
            end else begin
                r = sub ? {1'b0, w[7:0]} - {1'b0, b} - {8'h00, cin}
                        : {1'b0, w[7:0]} + {1'b0, b} + {8'h00, cin};
                h = sub ? {1'b0, w[3:0]} - {1'b0, b[3:0]} - {4'h0, cin}
                        : {1'b0, w[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
                e_flg[`ALEU_FLAG_C] = r[8];
                e_flg[`ALEU_FLAG_H] = h[4];
                e_flg[`ALEU_FLAG_V] = (w[7] ^ r[7]) & (w[7] ^ b[7] ^ ~sub);
            end
            e_pair[7:0] = r[7:0];
            e_flg[`ALEU_FLAG_Z] = r[7:0] == 8'h00;
            e_flg[`ALEU_FLAG_N] = r[7];
        end
    endtask : expect_op

    task automatic chk_res(input logic word);
        cmp_data({15'h0000, rv}, 16'h0001);
        cmp_data({15'h0000, res.wr_hi}, {15'h0000, word});
        cmp_data({word ? res.hi : 8'h00, res.lo},
                 {word ? e_pair[15:8] : 8'h00, e_pair[7:0]});
        cmp_flags(flg, e_flg);
        cmp_flags(res.flags, e_flg);
    endtask : chk_res

    // One operation; the unused operand field carries a decoy value
    task automatic do_op(input aleu_pkg::aleu_op_e op,
                         input logic [15:0] w, input logic [7:0] b);
        int   lat;
        logic word;
        word = op inside {aleu_pkg::ALEU_WORD_ADD_IMMEDIATE,
                          aleu_pkg::ALEU_WORD_SUB_IMMEDIATE};
        @(negedge clk);
        req = '{op, w[7:0], w[15:8], b, b};
        if (word || op inside {aleu_pkg::ALEU_SUB_CONSTANT,
            aleu_pkg::ALEU_SUB_CONST_WITH_CARRY,
            aleu_pkg::ALEU_AND_CONSTANT}) begin
            req.src_reg = ~b;
        end else begin
            req.konst = ~b;
        end
        req_v = 1'b1;
        cmp_data({15'h0000, rdy}, 16'h0001);
        @(negedge clk);
        req_v = 1'b0;
        expect_op(op, w, b);
        // Cycles counted from the accepting edge
        lat = 1;
        while (rv !== 1'b1 && lat < 4) begin
            @(negedge clk);
            lat++;
        end
        cmp_data(lat[15:0], {14'h0000, word ? `ALEU_WORD_CYCLES
                                             : `ALEU_BYTE_CYCLES});
        chk_res(word);
        @(negedge clk);
        cmp_data(pair, e_pair);
        cmp_data({15'h0000, rv}, 16'h0000);
    endtask : do_op

    task automatic t_add();
        do_op(aleu_pkg::ALEU_ADD, 16'h000f, 8'h01);
        do_op(aleu_pkg::ALEU_ADD, 16'h0080, 8'h80);
        do_op(aleu_pkg::ALEU_ADD_CARRY, 16'h007f, 8'h00);
    endtask : t_add

    task automatic t_sub();
        do_op(aleu_pkg::ALEU_SUB, 16'h0010, 8'h01);
        do_op(aleu_pkg::ALEU_SUB, 16'h0000, 8'h01);
        do_op(aleu_pkg::ALEU_SUB_WITH_CARRY, 16'h0005, 8'h02);
        do_op(aleu_pkg::ALEU_SUB_CONSTANT, 16'h0080, 8'h01);
        do_op(aleu_pkg::ALEU_SUB_CONST_WITH_CARRY, 16'h0003, 8'h05);
        do_op(aleu_pkg::ALEU_SUB_CONST_WITH_CARRY, 16'h0010, 8'h00);
    endtask : t_sub

    task automatic t_word();
        do_op(aleu_pkg::ALEU_ADD, 16'h000f, 8'h01);
        do_op(aleu_pkg::ALEU_WORD_ADD_IMMEDIATE, 16'hffff, 8'h01);
        do_op(aleu_pkg::ALEU_WORD_ADD_IMMEDIATE, 16'h7fff, 8'h01);
        do_op(aleu_pkg::ALEU_WORD_ADD_IMMEDIATE, 16'h12f0, 8'h3f);
        do_op(aleu_pkg::ALEU_WORD_SUB_IMMEDIATE, 16'h0000, 8'h01);
        do_op(aleu_pkg::ALEU_WORD_SUB_IMMEDIATE, 16'h8000, 8'h01);
    endtask : t_word

    task automatic t_and();
        do_op(aleu_pkg::ALEU_SUB, 16'h0000, 8'h01);
        do_op(aleu_pkg::ALEU_AND, 16'h00f0, 8'h0f);
        do_op(aleu_pkg::ALEU_AND_CONSTANT, 16'h00ff, 8'h80);
    endtask : t_and

    // Back-to-back byte ops, then a request held through a word op
    task automatic t_b2b();
        @(negedge clk);
        req = '{aleu_pkg::ALEU_ADD, 8'hff, 8'h00, 8'h01, 8'h00};
        req_v = 1'b1;
        @(negedge clk);
        expect_op(aleu_pkg::ALEU_ADD, 16'h00ff, 8'h01);
        chk_res(1'b0);
        req = '{aleu_pkg::ALEU_ADD_CARRY, 8'h10, 8'h00, 8'h20, 8'h00};
        @(negedge clk);
        expect_op(aleu_pkg::ALEU_ADD_CARRY, 16'h0010, 8'h20);
        chk_res(1'b0);
        req = '{aleu_pkg::ALEU_WORD_ADD_IMMEDIATE, 8'h34, 8'h12, 8'h00,
                8'h01};
        @(negedge clk);
        cmp_data({15'h0000, rdy}, 16'h0000);
        cmp_data({15'h0000, rv}, 16'h0000);
        req = '{aleu_pkg::ALEU_AND, 8'hf0, 8'h00, 8'h3c, 8'hff};
        @(negedge clk);
        expect_op(aleu_pkg::ALEU_WORD_ADD_IMMEDIATE, 16'h1234, 8'h01);
        chk_res(1'b1);
        cmp_data({15'h0000, rdy}, 16'h0001);
        @(negedge clk);
        req_v = 1'b0;
        expect_op(aleu_pkg::ALEU_AND, 16'h00f0, 8'h3c);
        chk_res(1'b0);
        @(negedge clk);
        cmp_data({15'h0000, rv}, 16'h0000);
    endtask : t_b2b

    initial begin
        rstn = 1'b0;
        req_v = 1'b0;
        req = '0;
        e_flg = `ALEU_FLAGS_RESET;
        e_pair = 16'h0000;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        t_add();
        t_sub();
        t_word();
        t_and();
        t_b2b();
        complete_run();
    end
endmodule : arith_logic_exec_unit_tb_top
`default_nettype wire
